// file: rtl/tsw_pkg.sv
package tsw_pkg;

	// ==========================================================
	// Slave address preambles and selector codes
	localparam logic [3:0] PRE_THERMAL = 4'h3;
	localparam logic [3:0] PRE_LOCK = 4'h6;
	localparam logic [2:0] SEL_REV_SET = 3'h1;
	localparam logic [2:0] SEL_REV_CLEAR = 3'h3;

	// ==========================================================
	// Thermal register pointer values
	localparam logic [2:0] REG_CAPABILITIES = 3'h0;
	localparam logic [2:0] REG_CONTROL = 3'h1;
	localparam logic [2:0] REG_UPPER = 3'h2;
	localparam logic [2:0] REG_LOWER = 3'h3;
	localparam logic [2:0] REG_CRITICAL = 3'h4;
	localparam logic [2:0] REG_TEMPERATURE = 3'h5;
	localparam logic [2:0] REG_VENDOR = 3'h6;
	localparam logic [2:0] REG_PART_REV = 3'h7;

	// ==========================================================
	// Reset and constant values
	localparam logic [15:0] CAPABILITIES_VALUE = 16'h007F;
	localparam logic [15:0] WRITABLE_RESET = 16'h0000;
	// Arbitrary identity values, not tied to any real part
	localparam logic [15:0] VENDOR_CODE_VALUE = 16'h5A5A;
	localparam logic [15:0] PART_REV_VALUE = 16'h0101;

	// ==========================================================
	// Control register fields and write masks
	localparam int CTL_MODE_INT = 0;
	localparam int CTL_POL_HIGH = 1;
	localparam int CTL_CRIT_ONLY = 2;
	localparam int CTL_ENABLE = 3;
	localparam int CTL_STATUS = 4;
	localparam int CTL_CLEAR = 5;
	localparam int CTL_ALARM_LOCK = 6;
	localparam int CTL_CRIT_LOCK = 7;
	localparam int CTL_SHUTDOWN = 8;
	localparam logic [15:0] CTL_STORE_MASK = 16'h07CF;
	localparam logic [15:0] CTL_LOCKED_MASK = 16'h060B;
	localparam logic [15:0] LIMIT_MASK = 16'h1FFC;

	// ==========================================================
	// Temperature reading layout
	localparam int TEMP_BITS = 13;
	localparam int TEMP_CRIT_BIT = 15;
	localparam int TEMP_UPPER_BIT = 14;
	localparam int TEMP_LOWER_BIT = 13;

	// ==========================================================
	// Memory guard and frame counting
	localparam logic [7:0] LOWER_HALF_SIZE = 8'h80;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] LOCK_WRITE_BYTES = 2'h2;
	localparam logic [1:0] THERMAL_WRITE_BYTES = 2'h3;

	// ==========================================================
	// Conversion timing
	localparam int CLOCK_KHZ = 250000;
	localparam int CONV_PERIOD_MS = 100;
	localparam int CONV_CYCLES = CONV_PERIOD_MS * CLOCK_KHZ;

	// Serial frame states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b011,
		ST_RX = 3'b010,
		ST_TX = 3'b110,
		ST_TX_ACK = 3'b111,
		ST_SKIP = 3'b101
	} tsw_state_e;

	typedef enum logic [1:0] {
		TGT_NONE = 2'b00,
		TGT_THERMAL = 2'b01,
		TGT_LOCK = 2'b11
	} tsw_target_e;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_PERM_SET = 2'b01,
		OP_REV_SET = 2'b11,
		OP_REV_CLEAR = 2'b10
	} tsw_lock_op_e;

endpackage

// file: rtl/tsw_link_rx.sv
`timescale 1ns/1ps

// ==========================================================
// Link side shifter, clocked by the serial clock itself
module tsw_link_rx (
	input wire logic scl,
	input wire logic rst,
	input wire logic sda_in,
	output logic [7:0] shift_data,
	output logic rise_toggle
);

	typedef struct packed {
		logic [7:0] shreg;
		logic tog;
	} tsw_link_s;

	tsw_link_s st;
	tsw_link_s next_st;

	// Every rising serial clock shifts one data bit and flips the toggle
	always_comb begin
		next_st = st;
		next_st.shreg = {st.shreg[6:0], sda_in};
		next_st.tog = ~st.tog;
	end

	// The shift value stays still for a whole serial clock period, which
	// lets the system side sample it after the toggle has crossed
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign shift_data = st.shreg;
	assign rise_toggle = st.tog;

endmodule

// file: rtl/tsw_top.sv
`timescale 1ns/1ps

// How it works
// - Lower 128 memory bytes refuse writes while either lock flag is set.
// - Lock commands use address preamble 0110; memory uses 1010.
// - Permanent lock commands match address bits 3..1 to the pin levels.
// - High voltage on pin 0 reads as 1; reversible set 001, clear 011.
// - High voltage lost before STOP turns a reversible request into permanent.
// - Lock address LSB 1 queries a flag, LSB 0 sets or clears it.
// - Lock writes ack address, dummy address and data, then write after STOP.
// - Lock query returns no data: NACK when set, ACK when clear.
// - Permanent lock blocks all lock commands; reversible set refused if set.
// - Conversion every 100 ms; result held in shutdown; reads do not disturb.
// - Reading bits 12..0 two's complement, LSB 0.0625 degrees.
// - Reading bits 15..13 show limit relations regardless of alert settings.
// - Reading compared to upper, lower and critical limits to raise alert.
// - Control selects interrupt or comparator mode and alert polarity.
// - Writable thermal registers reset to zero.
// - Alert output starts disabled with active low polarity.
// - Outside shutdown, a limit write that creates an event condition raises it at once.
// - Eight 16-bit registers behind a pointer that resets to capabilities.
// - Limits are two's complement with LSB 0.25 degrees.
// - Read-only vendor code and part and revision code registers.
// - Capabilities register reads constant 0x007F.
// - Preamble 0011 selects the thermal register space.
// - Thermal write is address, pointer, two data bytes; STOP commits.
module tsw_top #(
	parameter int unsigned CONV_CYCLES = tsw_pkg::CONV_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_pin_0,
	input wire logic addr_pin_1,
	input wire logic addr_pin_2,
	input wire logic high_voltage_detect,
	input wire logic [12:0] adc_value,
	input wire logic ee_wr_req,
	input wire logic [7:0] ee_wr_addr,
	output logic ee_wr_grant,
	output logic ee_wr_refuse,
	output logic lower_half_lock,
	output logic wp_write_cycle,
	output logic event_o,
	output logic event_oe
);

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] tog_s;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic [3:0] pin_s3;
		logic scl_q;
		logic sda_q;
		logic tog_q;
		logic [3:0] pins;
		tsw_pkg::tsw_state_e state;
		tsw_pkg::tsw_state_e after_ack;
		tsw_pkg::tsw_target_e target;
		tsw_pkg::tsw_lock_op_e lock_op;
		logic [3:0] bitcnt;
		logic [1:0] nbytes;
		logic rw;
		logic hv_held;
		logic ack_want;
		logic ack_stage;
		logic [7:0] tx_byte;
		logic tx_low;
		logic [2:0] ptr;
		logic [15:0] wdata;
		logic perm_flag;
		logic rev_flag;
		logic [15:0] control;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] critical;
		logic [12:0] temp;
		logic [31:0] conv_cnt;
		logic evt_latch;
		logic cond_prev;
		logic sda_o;
		logic sda_oe;
		logic ee_grant;
		logic ee_refuse;
		logic lock_out;
		logic nv_pulse;
		logic event_o;
		logic event_oe;
	} tsw_state_s;

	tsw_state_s st;
	tsw_state_s next_st;
	logic [7:0] link_shift;
	logic link_toggle;

	// ==========================================================
	// Link clock domain
	tsw_link_rx u_link (
		.scl(scl),
		.rst(rst),
		.sda_in(sda_i),
		.shift_data(link_shift),
		.rise_toggle(link_toggle)
	);

	// ==========================================================
	// System clock domain: synchronisers, frame engine, thermal unit
	always_comb begin
		logic scl_fall;
		logic bus_start;
		logic bus_stop;
		logic rise;
		logic [7:0] byte_in;
		logic [15:0] rd_word;
		logic [2:0] pin_logic;
		logic hv_now;
		logic [3:0] agree;
		logic above_crit;
		logic above_upper;
		logic below_lower;
		logic cond;
		logic asserted;
		logic clear_req;
		logic [15:0] ctl_w;
		scl_fall = 1'b0;
		bus_start = 1'b0;
		bus_stop = 1'b0;
		rise = 1'b0;
		byte_in = link_shift;
		rd_word = '0;
		clear_req = 1'b0;
		ctl_w = '0;
		next_st = st;
		next_st.nv_pulse = 1'b0;

		// Three stage synchronisers; a change counts once stages two and three agree
		next_st.scl_s = {st.scl_s[1:0], scl};
		next_st.sda_s = {st.sda_s[1:0], sda_i};
		next_st.tog_s = {st.tog_s[1:0], link_toggle};
		next_st.pin_s1 = {high_voltage_detect, addr_pin_2, addr_pin_1, addr_pin_0};
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_s3 = st.pin_s2;
		agree = ~(st.pin_s2 ^ st.pin_s3);
		next_st.pins = (agree & st.pin_s3) | (~agree & st.pins);
		if (st.scl_s[1] == st.scl_s[2]) begin
			next_st.scl_q = st.scl_s[2];
			scl_fall = st.scl_q & ~st.scl_s[2];
		end
		if (st.sda_s[1] == st.sda_s[2]) begin
			next_st.sda_q = st.sda_s[2];
			bus_start = st.scl_q & st.sda_q & ~st.sda_s[2];
			bus_stop = st.scl_q & ~st.sda_q & st.sda_s[2];
		end
		if (st.tog_s[1] == st.tog_s[2]) begin
			next_st.tog_q = st.tog_s[2];
			rise = st.tog_q ^ st.tog_s[2];
		end
		hv_now = st.pins[3];
		pin_logic = {st.pins[2], st.pins[1], st.pins[0] | hv_now};

		// Limit comparison on the stored reading and the live limits
		above_crit = $signed(st.temp) > $signed(st.critical[12:0]);
		above_upper = $signed(st.temp) > $signed(st.upper[12:0]);
		below_lower = $signed(st.temp) < $signed(st.lower[12:0]);
		if (st.control[tsw_pkg::CTL_CRIT_ONLY]) begin
			cond = above_crit;
		end else begin
			cond = above_crit | above_upper | below_lower;
		end
		asserted = st.control[tsw_pkg::CTL_ENABLE] & st.evt_latch;

		// Read mux for the register pointer
		case (st.ptr)
			tsw_pkg::REG_CAPABILITIES: rd_word = tsw_pkg::CAPABILITIES_VALUE;
			tsw_pkg::REG_CONTROL: begin
				rd_word = st.control;
				rd_word[tsw_pkg::CTL_STATUS] = asserted;
			end
			tsw_pkg::REG_UPPER: rd_word = st.upper;
			tsw_pkg::REG_LOWER: rd_word = st.lower;
			tsw_pkg::REG_CRITICAL: rd_word = st.critical;
			tsw_pkg::REG_TEMPERATURE: begin
				rd_word[tsw_pkg::TEMP_BITS-1:0] = st.temp;
				rd_word[tsw_pkg::TEMP_CRIT_BIT] = above_crit;
				rd_word[tsw_pkg::TEMP_UPPER_BIT] = above_upper;
				rd_word[tsw_pkg::TEMP_LOWER_BIT] = below_lower;
			end
			tsw_pkg::REG_VENDOR: rd_word = tsw_pkg::VENDOR_CODE_VALUE;
			default: rd_word = tsw_pkg::PART_REV_VALUE;
		endcase

		// High voltage must stay from START to STOP
		if (!hv_now) begin
			next_st.hv_held = 1'b0;
		end

		// Serial frame engine
		case (st.state)
			tsw_pkg::ST_ADDR, tsw_pkg::ST_RX: begin
				if (rise) begin
					next_st.bitcnt = st.bitcnt + 4'h1;
					if (st.bitcnt == tsw_pkg::BITS_PER_BYTE - 4'h1) begin
						next_st.state = tsw_pkg::ST_ACK;
						next_st.ack_stage = 1'b0;
						next_st.ack_want = 1'b1;
						next_st.after_ack = tsw_pkg::ST_RX;
						if (st.state == tsw_pkg::ST_ADDR) begin
							next_st.rw = byte_in[0];
							next_st.ack_want = 1'b0;
							next_st.after_ack = tsw_pkg::ST_SKIP;
							if (byte_in[7:4] == tsw_pkg::PRE_THERMAL
									&& byte_in[3:1] == pin_logic) begin
								next_st.target = tsw_pkg::TGT_THERMAL;
								next_st.ack_want = 1'b1;
								next_st.after_ack = byte_in[0] ? tsw_pkg::ST_TX : tsw_pkg::ST_RX;
								next_st.tx_byte = rd_word[15:8];
								next_st.tx_low = 1'b0;
							end else if (byte_in[7:4] == tsw_pkg::PRE_LOCK
									&& !st.perm_flag) begin
								next_st.target = tsw_pkg::TGT_LOCK;
								if (st.hv_held && hv_now
										&& byte_in[3:2] == pin_logic[2:1]) begin
									if (byte_in[3:1] == tsw_pkg::SEL_REV_SET) begin
										next_st.lock_op = tsw_pkg::OP_REV_SET;
										next_st.ack_want = ~st.rev_flag;
									end else if (byte_in[3:1] == tsw_pkg::SEL_REV_CLEAR) begin
										next_st.lock_op = tsw_pkg::OP_REV_CLEAR;
										next_st.ack_want = byte_in[0] ? ~st.rev_flag : 1'b1;
									end
								end else if (byte_in[3:1] == pin_logic) begin
									next_st.lock_op = tsw_pkg::OP_PERM_SET;
									next_st.ack_want = 1'b1;
								end
								// A query carries no data: the host stops after the ack
								if (!byte_in[0]) begin
									next_st.after_ack = tsw_pkg::ST_RX;
								end
							end
						end else if (st.target == tsw_pkg::TGT_THERMAL) begin
							if (st.nbytes == 2'h0) begin
								next_st.ptr = byte_in[2:0];
							end else if (st.nbytes == 2'h1) begin
								next_st.wdata[15:8] = byte_in;
							end else begin
								next_st.wdata[7:0] = byte_in;
							end
						end
						if (st.state == tsw_pkg::ST_RX && st.nbytes != tsw_pkg::THERMAL_WRITE_BYTES) begin
							next_st.nbytes = st.nbytes + 2'h1;
						end
					end
				end
			end
			tsw_pkg::ST_ACK: begin
				if (scl_fall) begin
					next_st.bitcnt = '0;
					if (!st.ack_stage) begin
						next_st.ack_stage = 1'b1;
						next_st.sda_oe = st.ack_want;
					end else begin
						next_st.sda_oe = 1'b0;
						next_st.state = st.ack_want ? st.after_ack : tsw_pkg::ST_SKIP;
						if (st.ack_want && st.after_ack == tsw_pkg::ST_TX) begin
							next_st.sda_oe = ~st.tx_byte[7];
							next_st.bitcnt = 4'h1;
						end
					end
				end
			end
			tsw_pkg::ST_TX: begin
				if (scl_fall) begin
					if (st.bitcnt == tsw_pkg::BITS_PER_BYTE) begin
						next_st.sda_oe = 1'b0;
						next_st.state = tsw_pkg::ST_TX_ACK;
						next_st.ack_stage = 1'b0;
						next_st.tx_low = ~st.tx_low;
						next_st.tx_byte = st.tx_low ? rd_word[15:8] : rd_word[7:0];
					end else begin
						next_st.sda_oe = ~st.tx_byte[3'h7 - st.bitcnt[2:0]];
						next_st.bitcnt = st.bitcnt + 4'h1;
					end
				end
			end
			tsw_pkg::ST_TX_ACK: begin
				if (rise) begin
					next_st.ack_stage = ~st.sda_q;
				end
				if (scl_fall) begin
					if (st.ack_stage) begin
						next_st.state = tsw_pkg::ST_TX;
						next_st.sda_oe = ~st.tx_byte[7];
						next_st.bitcnt = 4'h1;
					end else begin
						next_st.state = tsw_pkg::ST_SKIP;
					end
				end
			end
			default: begin
				next_st.sda_oe = 1'b0;
			end
		endcase

		// STOP commits pending writes; START opens a fresh frame
		if (bus_stop) begin
			if (st.target == tsw_pkg::TGT_LOCK && !st.rw
					&& st.nbytes >= tsw_pkg::LOCK_WRITE_BYTES) begin
				next_st.nv_pulse = st.lock_op != tsw_pkg::OP_NONE;
				if (st.lock_op == tsw_pkg::OP_PERM_SET || !st.hv_held || !hv_now) begin
					next_st.perm_flag = st.lock_op != tsw_pkg::OP_NONE;
				end else if (st.lock_op == tsw_pkg::OP_REV_SET) begin
					next_st.rev_flag = 1'b1;
				end else begin
					next_st.rev_flag = 1'b0;
				end
			end
			if (st.target == tsw_pkg::TGT_THERMAL && !st.rw
					&& st.nbytes == tsw_pkg::THERMAL_WRITE_BYTES) begin
				case (st.ptr)
					tsw_pkg::REG_CONTROL: begin
						ctl_w = st.wdata & tsw_pkg::CTL_STORE_MASK;
						if (st.control[tsw_pkg::CTL_ALARM_LOCK] || st.control[tsw_pkg::CTL_CRIT_LOCK]) begin
							ctl_w = (ctl_w & ~tsw_pkg::CTL_LOCKED_MASK)
								| (st.control & tsw_pkg::CTL_LOCKED_MASK);
						end
						ctl_w[tsw_pkg::CTL_ALARM_LOCK] = ctl_w[tsw_pkg::CTL_ALARM_LOCK]
							| st.control[tsw_pkg::CTL_ALARM_LOCK];
						ctl_w[tsw_pkg::CTL_CRIT_LOCK] = ctl_w[tsw_pkg::CTL_CRIT_LOCK]
							| st.control[tsw_pkg::CTL_CRIT_LOCK];
						next_st.control = ctl_w;
						clear_req = st.wdata[tsw_pkg::CTL_CLEAR];
					end
					tsw_pkg::REG_UPPER: begin
						if (!st.control[tsw_pkg::CTL_ALARM_LOCK]) begin
							next_st.upper = st.wdata & tsw_pkg::LIMIT_MASK;
						end
					end
					tsw_pkg::REG_LOWER: begin
						if (!st.control[tsw_pkg::CTL_ALARM_LOCK]) begin
							next_st.lower = st.wdata & tsw_pkg::LIMIT_MASK;
						end
					end
					tsw_pkg::REG_CRITICAL: begin
						if (!st.control[tsw_pkg::CTL_CRIT_LOCK]) begin
							next_st.critical = st.wdata & tsw_pkg::LIMIT_MASK;
						end
					end
					default: begin
						next_st.ptr = st.ptr;
					end
				endcase
			end
			next_st.state = tsw_pkg::ST_IDLE;
			next_st.target = tsw_pkg::TGT_NONE;
			next_st.sda_oe = 1'b0;
		end
		if (bus_start) begin
			next_st.state = tsw_pkg::ST_ADDR;
			next_st.target = tsw_pkg::TGT_NONE;
			next_st.lock_op = tsw_pkg::OP_NONE;
			next_st.bitcnt = '0;
			next_st.nbytes = '0;
			next_st.sda_oe = 1'b0;
			next_st.hv_held = hv_now;
		end

		// Conversion timer on the system clock; shutdown freezes the reading
		if (st.conv_cnt >= CONV_CYCLES - 1) begin
			next_st.conv_cnt = '0;
			if (!st.control[tsw_pkg::CTL_SHUTDOWN]) begin
				next_st.temp = adc_value;
			end
		end else begin
			next_st.conv_cnt = st.conv_cnt + 32'h1;
		end

		// Event tracks live limits, so a limit write acts without a new sample
		if (!st.control[tsw_pkg::CTL_SHUTDOWN]) begin
			next_st.cond_prev = cond;
			if (st.control[tsw_pkg::CTL_MODE_INT]) begin
				// Clear first, so a new crossing in the same cycle still sets
				if (clear_req) begin
					next_st.evt_latch = 1'b0;
				end
				if ((cond && !st.cond_prev) || above_crit) begin
					next_st.evt_latch = 1'b1;
				end
			end else begin
				next_st.evt_latch = cond;
			end
		end

		// Open drain alert: disabled active low leaves the pin released
		next_st.event_oe = st.control[tsw_pkg::CTL_POL_HIGH] ? ~asserted : asserted;

		// Lower half memory guard
		next_st.lock_out = st.perm_flag | st.rev_flag;
		next_st.ee_refuse = ee_wr_req && ee_wr_addr < tsw_pkg::LOWER_HALF_SIZE
			&& (st.perm_flag || st.rev_flag);
		next_st.ee_grant = ee_wr_req && !(ee_wr_addr < tsw_pkg::LOWER_HALF_SIZE
			&& (st.perm_flag || st.rev_flag));
	end

	// All writable thermal registers and the pointer clear on reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sda_o = st.sda_o;
	assign sda_oe = st.sda_oe;
	assign ee_wr_grant = st.ee_grant;
	assign ee_wr_refuse = st.ee_refuse;
	assign lower_half_lock = st.lock_out;
	assign wp_write_cycle = st.nv_pulse;
	assign event_o = st.event_o;
	assign event_oe = st.event_oe;

endmodule

// file: verification/tsw_checker.sv
`timescale 1ns/1ps

// ==========================================================
// Port checks for the sensor and lock block
module tsw_checker #(
	parameter int unsigned CONV_CYCLES = 200
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic addr_pin_0,
	input wire logic addr_pin_1,
	input wire logic addr_pin_2,
	input wire logic high_voltage_detect,
	input wire logic [12:0] adc_value,
	input wire logic ee_wr_req,
	input wire logic [7:0] ee_wr_addr,
	input wire logic ee_wr_grant,
	input wire logic ee_wr_refuse,
	input wire logic lower_half_lock,
	input wire logic wp_write_cycle,
	input wire logic event_o,
	input wire logic event_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// ==========================================================
	// Cycles since the last lock write pulse, saturating
	logic [2:0] since_wp;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			since_wp <= 3'h7;
		else if (wp_write_cycle)
			since_wp <= 3'h0;
		else if (since_wp != 3'h7)
			since_wp <= since_wp + 3'h1;
	end

	// ==========================================================
	// Sequences
	sequence s_quiet;
		(!event_oe && !sda_oe && !lower_half_lock && !wp_write_cycle)[*8];
	endsequence
	sequence s_wp_near;
		##[0:4] wp_write_cycle;
	endsequence

	// ==========================================================
	// Properties
	property p_refuse;
		ee_wr_req && ee_wr_addr < 8'h80 |=> ee_wr_refuse == lower_half_lock;
	endproperty
	a_refuse: assert property (p_refuse) else $error("lower half guard wrong");
	property p_upper;
		ee_wr_req && ee_wr_addr >= 8'h80 |=> ee_wr_grant && !ee_wr_refuse;
	endproperty
	a_upper: assert property (p_upper) else $error("upper half refused");
	property p_one_answer;
		ee_wr_req |=> ee_wr_grant != ee_wr_refuse;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("grant and refuse clash");
	property p_no_req;
		!ee_wr_req |=> !ee_wr_grant && !ee_wr_refuse;
	endproperty
	a_no_req: assert property (p_no_req) else $error("answer without request");
	property p_pulse;
		wp_write_cycle |=> !wp_write_cycle;
	endproperty
	a_pulse: assert property (p_pulse) else $error("write cycle pulse too long");
	property p_lock_moves;
		$changed(lower_half_lock) |-> (since_wp < 3'h6) or s_wp_near;
	endproperty
	a_lock_moves: assert property (p_lock_moves) else $error("lock moved alone");
	property p_ack_edge;
		$changed(sda_oe) |-> !scl;
	endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("data moved with clock high");
	property p_reset_quiet;
		$fell(rst) |-> s_quiet;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("activity after reset");
	property p_open_drain;
		sda_o == 1'b0 && event_o == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain level high");
endmodule

// file: verification/tsw_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// Host master: makes the serial clock, pulls data low
module tsw_host_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	localparam realtime Q = 31.25;

	// Idle bus until the first frame
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Start; also a repeated start from a low clock
	task automatic start();
		sda_pull = 1'b0;
		#Q;
		scl = 1'b1;
		#Q;
		sda_pull = 1'b1;
		#Q;
		scl = 1'b0;
		#Q;
	endtask

	// Nine bits: data moves only with the clock low, sampled mid-high
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_pull = !tx[i];
			#Q;
			scl = 1'b1;
			#Q;
			rx[i] = sda;
			#Q;
			scl = 1'b0;
			#Q;
		end
	endtask

	// Stop; the clock then stands still high
	task automatic stop();
		sda_pull = 1'b1;
		#Q;
		scl = 1'b1;
		#Q;
		sda_pull = 1'b0;
		#(2 * Q);
	endtask
endmodule

// file: verification/temp_sensor_and_write_protect_test.sv
`timescale 1ns/1ps

// ==========================================================
// Host frames on the link, guard requests on the system side
module temp_sensor_and_write_protect_test;
	localparam int unsigned CONV = 200;
	localparam logic [7:0] TA = {tsw_pkg::PRE_THERMAL, 4'h0};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic scl, h_pull, sda_i, sda_o, sda_oe, g, rf, ok;
	logic addr_pin_0 = 1'b0;
	logic addr_pin_1 = 1'b0;
	logic addr_pin_2 = 1'b0;
	logic high_voltage_detect = 1'b0;
	logic [12:0] adc_value = 13'h0200;
	logic ee_wr_req = 1'b0;
	logic [7:0] ee_wr_addr = 8'h00;
	logic ee_wr_grant, ee_wr_refuse, lower_half_lock, wp_write_cycle, event_o, event_oe;
	logic hv_drop = 1'b0;
	logic [15:0] v;
	int n_errors = 0;
	int checks_done = 0;
	int n_wp = 0;

	always #2 clock = ~clock;
	// Pulled-up wire: low whenever either side pulls
	assign sda_i = !(h_pull || sda_oe);
	// Count lock write cycles
	always @(posedge clock) begin
		if (wp_write_cycle)
			n_wp++;
	end

	tsw_host_model h (.scl(scl), .sda_pull(h_pull), .sda(sda_i));
	tsw_top #(.CONV_CYCLES(CONV)) dut (.clock(clock), .rst(rst), .scl(scl), .sda_i(sda_i),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_0(addr_pin_0), .addr_pin_1(addr_pin_1),
		.addr_pin_2(addr_pin_2), .high_voltage_detect(high_voltage_detect),
		.adc_value(adc_value), .ee_wr_req(ee_wr_req), .ee_wr_addr(ee_wr_addr),
		.ee_wr_grant(ee_wr_grant), .ee_wr_refuse(ee_wr_refuse),
		.lower_half_lock(lower_half_lock), .wp_write_cycle(wp_write_cycle),
		.event_o(event_o), .event_oe(event_oe));

	// ==========================================================
	// Compare and report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp, input string what);
		chk({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// Access tasks
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic do_reset();
		tick();
		rst = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		rst = 1'b0;
		repeat (10) @(posedge clock);
	endtask
	// Address, then nb bytes from the top of d; ok if all acked
	task automatic wr(input logic [7:0] a, input logic [23:0] d, input int nb, output logic ok);
		logic [8:0] r;
		h.start();
		h.xfer({a, 1'b1}, r);
		ok = !r[0];
		for (int i = 0; i < nb; i++) begin
			h.xfer({d[23 - 8 * i -: 8], 1'b1}, r);
			ok = ok && !r[0];
		end
		// Dropping high voltage before the stop makes it permanent
		if (hv_drop)
			high_voltage_detect = 1'b0;
		h.stop();
		repeat (20) @(posedge clock);
	endtask
	task automatic tw(input logic [2:0] p, input logic [15:0] d);
		wr(TA, {5'h00, p, d}, 3, ok);
		chkb(ok, 1'b1, "register write ack");
	endtask
	// Lock command: two dummy bytes on a write
	task automatic lk(input logic [2:0] sel, input logic rw);
		wr({tsw_pkg::PRE_LOCK, sel, rw}, 24'hA5C3FF, rw ? 0 : 2, ok);
	endtask
	// Register read; a negative pointer keeps the last one
	task automatic rd(input int p, output logic [15:0] v);
		logic [8:0] r;
		if (p >= 0) begin
			h.start();
			h.xfer({TA, 1'b1}, r);
			h.xfer({5'h00, p[2:0], 1'b1}, r);
		end
		h.start();
		h.xfer({TA | 8'h01, 1'b1}, r);
		h.xfer({8'hFF, 1'b0}, r);
		v[15:8] = r[8:1];
		h.xfer({8'hFF, 1'b1}, r);
		v[7:0] = r[8:1];
		h.stop();
	endtask
	task automatic mem(input logic [7:0] a);
		tick();
		ee_wr_req = 1'b1;
		ee_wr_addr = a;
		tick();
		ee_wr_req = 1'b0;
		g = ee_wr_grant;
		rf = ee_wr_refuse;
	endtask

	// ==========================================================
	// Tests
	initial begin
		do_reset();
		chkb(event_oe, 1'b0, "alert idle");
		rd(-1, v);
		chk(v, tsw_pkg::CAPABILITIES_VALUE, "first pointer");
		for (int p = 1; p < 5; p++) begin
			rd(p, v);
			chk(v, 16'h0000, "reset value");
		end
		tw(tsw_pkg::REG_CAPABILITIES, 16'hFFFF);
		rd(0, v);
		chk(v, 16'h007F, "capabilities");
		rd(6, v);
		chk(v, tsw_pkg::VENDOR_CODE_VALUE, "vendor");
		rd(7, v);
		chk(v, tsw_pkg::PART_REV_VALUE, "part");
		tw(tsw_pkg::REG_UPPER, 16'h0403);
		rd(2, v);
		chk(v, 16'h0400, "limit format");
		tw(tsw_pkg::REG_LOWER, 16'h0100);
		tw(tsw_pkg::REG_CRITICAL, 16'h0800);
		repeat (2 * CONV) @(posedge clock);
		tw(tsw_pkg::REG_CONTROL, 16'h0008);
		chkb(event_oe, 1'b0, "in window");
		tw(tsw_pkg::REG_UPPER, 16'h0190);
		chkb(event_oe, 1'b1, "limit event");
		rd(5, v);
		chk(v, 16'h4200, "reading");
		tw(tsw_pkg::REG_CONTROL, 16'h000A);
		chkb(event_oe, 1'b0, "polarity");
		tw(tsw_pkg::REG_CONTROL, 16'h0009);
		tw(tsw_pkg::REG_CONTROL, 16'h0029);
		chkb(event_oe, 1'b0, "cleared");
		tw(tsw_pkg::REG_CONTROL, 16'h010A);
		tick();
		adc_value = 13'h0050;
		repeat (2 * CONV) @(posedge clock);
		rd(5, v);
		chk(v, 16'h4200, "frozen reading");
		$display("test thermal finished");
		mem(8'h7F);
		chkb(g, 1'b1, "open grant");
		lk(3'h0, 1'b1);
		chkb(ok, 1'b1, "query clear");
		tick();
		high_voltage_detect = 1'b1;
		lk(tsw_pkg::SEL_REV_SET, 1'b0);
		chkb(ok, 1'b1, "set acks");
		chkb(n_wp == 1, 1'b1, "write cycle");
		mem(8'h7F);
		chkb(rf, 1'b1, "locked refuse");
		chkb(g, 1'b0, "locked grant");
		mem(8'h80);
		chkb(g, 1'b1, "upper grant");
		lk(tsw_pkg::SEL_REV_SET, 1'b0);
		chkb(ok, 1'b0, "double set");
		lk(tsw_pkg::SEL_REV_SET, 1'b1);
		chkb(ok, 1'b0, "query set");
		tick();
		addr_pin_1 = 1'b1;
		lk(tsw_pkg::SEL_REV_CLEAR, 1'b0);
		chkb(lower_half_lock, 1'b0, "clear");
		tick();
		addr_pin_1 = 1'b0;
		hv_drop = 1'b1;
		lk(tsw_pkg::SEL_REV_SET, 1'b0);
		hv_drop = 1'b0;
		lk(3'h0, 1'b1);
		chkb(ok, 1'b0, "became permanent");
		tick();
		high_voltage_detect = 1'b1;
		addr_pin_1 = 1'b1;
		lk(tsw_pkg::SEL_REV_CLEAR, 1'b0);
		chkb(lower_half_lock, 1'b1, "permanent holds");
		$display("test reversible finished");
		do_reset();
		tick();
		high_voltage_detect = 1'b0;
		addr_pin_1 = 1'b0;
		addr_pin_2 = 1'b1;
		addr_pin_0 = 1'b1;
		lk(3'h4, 1'b0);
		chkb(ok, 1'b0, "pin mismatch");
		lk(3'h5, 1'b0);
		chkb(lower_half_lock, 1'b1, "pin match");
		chkb(n_wp == 4, 1'b1, "write cycles");
		$display("test permanent finished");
		conclude();
	end

	// Watchdog: the run needs about 150 us
	initial begin
		#400_000;
		n_errors++;
		conclude();
	end
endmodule

bind tsw_top tsw_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clock(clock), .rst(rst),
	.scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_0(addr_pin_0),
	.addr_pin_1(addr_pin_1), .addr_pin_2(addr_pin_2),
	.high_voltage_detect(high_voltage_detect), .adc_value(adc_value),
	.ee_wr_req(ee_wr_req), .ee_wr_addr(ee_wr_addr), .ee_wr_grant(ee_wr_grant),
	.ee_wr_refuse(ee_wr_refuse), .lower_half_lock(lower_half_lock),
	.wp_write_cycle(wp_write_cycle), .event_o(event_o), .event_oe(event_oe));
